/* File: inc/sdt_pkg.sv */
package sdt_pkg;
  // data and address widths of the modelled x16 part
  localparam int DATA_W  = 16;
  localparam int LANE_N  = 2;
  localparam int ROW_W   = 13;
  localparam int COL_W   = 9;
  localparam int BANK_W  = 2;
  localparam int MEM_AW  = 8;                 // address bits per bank in this model (256 words)
  // cycle figures
  localparam int COLUMN_TO_COLUMN_CYCLES   = 1;
  localparam int SUSPEND_ENTRY_LATENCY     = 1;
  localparam int SUSPEND_EXIT_LATENCY      = 1;
  localparam int WRITE_MASK_LATENCY        = 0;
  localparam int WRITE_TO_INPUT_DELAY      = 0;
  localparam int READ_MASK_TURNOFF_LATENCY = 2;
  localparam int PRECHARGE_TO_OUTPUT_OFF_3 = 3;
  localparam int PRECHARGE_TO_OUTPUT_OFF_2 = 2;
  localparam int MODE_LOAD_RECOVERY        = 2;
  localparam int WRITE_DATA_TO_PRECHARGE   = 2;
  // internal precharge start after first clock past last write word
  localparam int CLK_PERIOD_PS            = 50000;
  localparam int AP_START_PS              = 7500;
  localparam int AP_START_CYCLES          = (AP_START_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRECHARGE_PERIOD_PS      = 20000;
  localparam int PRECHARGE_PERIOD_CYCLES  = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // wake-up refresh count
  localparam logic [1:0] WAKE_REFRESH_N   = 2'h2;
  // mode register fields
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam logic [2:0] MODE_RESET = 3'h3;  // burst 8, latency 2 after reset of the model
  // command encoding {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h8, CMD_NOP = 4'h7, CMD_ACT = 4'h3, CMD_READ = 4'h5, CMD_WRITE = 4'h4,
    CMD_STOP = 4'h6, CMD_PRE = 4'h2, CMD_REF = 4'h1, CMD_MRS = 4'h0
  } sdt_cmd_e;
  // one cycle of controller inputs
  typedef struct packed {
    logic                  cke;
    logic [3:0]            cmd;
    logic [BANK_W-1:0]     bank;
    logic [ROW_W-1:0]      addr;
    logic [LANE_N-1:0]     mask;
    logic [DATA_W-1:0]     wdata;
  } sdt_in_s;
  // data pin drive
  typedef struct packed {
    logic [DATA_W-1:0]     data;
    logic                  oe_n;
  } sdt_out_s;
endpackage : sdt_pkg

/* File: design/sdt_lane.sv */
`timescale 1ns/100ps
// one byte lane of a memory word: write unless masked (mask applies same edge)
module sdt_lane
  import sdt_pkg::*;
(
  input  wire logic       wr_i,
  input  wire logic       mask_i,
  input  wire logic [7:0] new_i,
  input  wire logic [7:0] old_i,
  output logic      [7:0] res_o
);
  // masked lane keeps its old contents
  assign res_o = (wr_i && !mask_i) ? new_i : old_i;
endmodule : sdt_lane

/* File: design/sdt_core.sv */
`timescale 1ns/100ps
// Overview of operation
// - cke low suspends after one cycle
// - cke high resumes one cycle later
// - write mask blocks same-edge data
// - read mask floats output two cycles later
// - first write word taken with command
// - precharge floats read data after latency
// - auto precharge starts after write delay in bursts longer than one word
module sdt_core
  import sdt_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire sdt_pkg::sdt_in_s  pin_i,
  output sdt_pkg::sdt_out_s      dq_o,
  output logic                   ready_o,
  output logic                   suspended_o
);
  // depth of the read pipe, covers latency three
  localparam int PIPE_N = 4;

  // storage: bank x word
  logic [DATA_W-1:0] mem_q [2**BANK_W][2**MEM_AW];

  // controller state
  logic              susp_q, susp_d;            // clock suspended
  logic              run_q, run_d;              // command slot enabled
  logic [1:0]        wake_q, wake_d;            // wake-up refreshes seen
  logic [2:0]        mode_q, mode_d;            // {cl3, bl code}
  logic              rd_q, rd_d;                // read burst active
  logic              wr_q, wr_d;                // write burst active
  logic              ap_q, ap_d;                // auto precharge armed
  logic [BANK_W-1:0] bank_q, bank_d;            // burst bank
  logic [MEM_AW-1:0] col_q, col_d;              // burst column
  logic [3:0]        left_q, left_d;            // words left in burst
  logic [3:0]        apcnt_q, apcnt_d;          // internal precharge timer
  logic [PIPE_N-1:0]             vld_q, vld_d;  // read data valid pipe
  logic [PIPE_N-1:0][DATA_W-1:0] dat_q, dat_d;  // read data pipe
  logic [PIPE_N-1:0]             mk_q, mk_d;    // read mask pipe
  logic [LANE_N-1:0] mask_q;                    // mask history, one deep
  logic [LANE_N-1:0] mask2_q;                   // mask history, one deep, sampled even while suspended
  sdt_out_s          out_q, out_d;

  // decoded command, ignored while suspended
  logic              live;
  logic [3:0]        cmd;
  logic [DATA_W-1:0] wword;
  logic [DATA_W-1:0] rword;
  logic [3:0]        blen;
  logic [MEM_AW-1:0] widx;
  logic [BANK_W-1:0] wbank;

  // suspend entry: cke sampled low freezes the next cycle
  assign live  = !susp_q;
  assign cmd   = live ? pin_i.cmd : CMD_NOP;
  // a new column command addresses its own word; a running burst uses the burst counter
  assign wbank = (cmd == CMD_WRITE || cmd == CMD_READ) ? pin_i.bank : bank_q;
  assign widx  = (cmd == CMD_WRITE || cmd == CMD_READ) ? pin_i.addr[MEM_AW-1:0] : col_q;
  assign rword = mem_q[wbank][widx];
  assign blen  = (mode_q[1:0] == 2'h0) ? 4'h1 : (mode_q[1:0] == 2'h1) ? 4'h2 :
                 (mode_q[1:0] == 2'h2) ? 4'h4 : 4'h8;

  for (genvar g = 0; g < LANE_N; g++) begin : g_lane
    sdt_lane u_lane (
      .wr_i  (live && (cmd == CMD_WRITE || wr_q)),
      .mask_i(pin_i.mask[g]),
      .new_i (pin_i.wdata[8*g +: 8]),
      .old_i (rword[8*g +: 8]),
      .res_o (wword[8*g +: 8])
    );
  end

  // next-state logic for the command engine
  always_comb begin
    susp_d  = !pin_i.cke;
    run_d   = run_q;
    wake_d  = wake_q;
    mode_d  = mode_q;
    rd_d    = rd_q;
    wr_d    = wr_q;
    ap_d    = ap_q;
    bank_d  = bank_q;
    col_d   = col_q;
    left_d  = left_q;
    apcnt_d = (apcnt_q != 4'h0) ? apcnt_q - 4'h1 : 4'h0;
    vld_d   = live ? {vld_q[PIPE_N-2:0], 1'b0} : vld_q;
    dat_d   = live ? {dat_q[PIPE_N-2:0], rword} : dat_q;
    mk_d    = live ? {mk_q[PIPE_N-2:0], 1'b0} : mk_q;
    // burst progress
    if (live && (rd_q || wr_q)) begin
      col_d  = col_q + 8'h01;
      left_d = left_q - 4'h1;
      if (left_q == 4'h1) begin
        rd_d = 1'b0;
        wr_d = 1'b0;
        if (ap_q) begin
          apcnt_d = 4'(AP_START_CYCLES + PRECHARGE_PERIOD_CYCLES);
        end
        ap_d = 1'b0;
      end
    end
    if (live && rd_q) begin
      vld_d[0] = 1'b1;
    end
    case (cmd)
      CMD_READ: begin
        rd_d = 1'b1;
        wr_d = 1'b0;
        bank_d = pin_i.bank;
        col_d = pin_i.addr[MEM_AW-1:0] + 8'h01;
        left_d = blen - 4'h1;
        ap_d = pin_i.addr[10];
        vld_d[0] = 1'b1;
        if (blen == 4'h1) begin
          rd_d = 1'b0;
        end
      end
      CMD_WRITE: begin
        wr_d = (blen != 4'h1);
        rd_d = 1'b0;
        bank_d = pin_i.bank;
        col_d = pin_i.addr[MEM_AW-1:0] + 8'h01;
        left_d = blen - 4'h1;
        ap_d = pin_i.addr[10];
      end
      CMD_STOP: begin
        rd_d = 1'b0;
        wr_d = 1'b0;
      end
      CMD_PRE: begin
        rd_d = 1'b0;
        wr_d = 1'b0;
        // turn-off equals read latency, so only the word fetched on this edge is dropped
        vld_d[0] = 1'b0;
      end
      CMD_REF: begin
        if (wake_q != WAKE_REFRESH_N) begin
          wake_d = wake_q + 2'h1;
        end
        run_d = (wake_q + 2'h1 >= WAKE_REFRESH_N);
      end
      CMD_MRS: begin
        mode_d = {pin_i.addr[MODE_CL_LSB], pin_i.addr[MODE_BL_LSB +: 2]};
      end
      default: begin
      end
    endcase
    // read mask floats output two cycles on
    // mask lands on the tap that feeds the output for either latency
    mk_d[0] = live ? (|pin_i.mask) : mk_q[0];
    mk_d[READ_MASK_TURNOFF_LATENCY - 1] = live ? (|pin_i.mask) : mk_q[READ_MASK_TURNOFF_LATENCY - 1];
    // output from the lane matching read latency
    out_d.data = mode_q[2] ? dat_q[1] : dat_q[0];
    out_d.oe_n = mode_q[2] ? !(vld_q[1] && !mk_q[1]) : !(vld_q[0] && !mk_q[0]);
    if (susp_q) begin
      out_d = out_q;
    end
  end

  // command engine registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      susp_q  <= 1'b0;
      run_q   <= 1'b0;
      wake_q  <= 2'h0;
      mode_q  <= MODE_RESET;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      ap_q    <= 1'b0;
      bank_q  <= '0;
      col_q   <= '0;
      left_q  <= 4'h0;
      apcnt_q <= 4'h0;
      vld_q   <= '0;
      dat_q   <= '0;
      mk_q    <= '0;
      out_q   <= '{data: '0, oe_n: 1'b1};
      mask_q  <= '0;
      mask2_q <= '0;
    end else begin
      susp_q  <= susp_d;
      run_q   <= run_d;
      wake_q  <= wake_d;
      mode_q  <= mode_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      ap_q    <= ap_d;
      bank_q  <= bank_d;
      col_q   <= col_d;
      left_q  <= left_d;
      apcnt_q <= apcnt_d;
      vld_q   <= vld_d;
      dat_q   <= dat_d;
      mk_q    <= mk_d;
      out_q   <= out_d;
      mask_q  <= live ? pin_i.mask : mask_q;
      mask2_q <= pin_i.mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (live && (cmd == CMD_WRITE || wr_q)) begin
      mem_q[wbank][widx] <= wword;
    end
  end

  // ready once resumed, woken, not precharging
  assign ready_o     = run_q && !susp_q && (apcnt_q == 4'h0);
  assign suspended_o = susp_q;
  assign dq_o        = out_q;
endmodule : sdt_core

/* File: bench/sdt_core_checker.sv */
`timescale 1ns/100ps
// watches the core pins for command timing relations
module sdt_core_checker
  import sdt_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire sdt_pkg::sdt_in_s  pin_i,
  input wire sdt_pkg::sdt_out_s dq_o,
  input wire logic              ready_o,
  input wire logic              suspended_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic       cl3_q;  // latency three chosen
  logic [1:0] ref_q;  // refreshes seen, saturating
  logic       tk;     // command taken this edge
  logic       rd;     // unmasked read taken
  assign tk = !suspended_o;
  assign rd = tk && ready_o && pin_i.cke && pin_i.cmd == CMD_READ && pin_i.mask == 2'h0;
  // track read latency and wake-up refreshes
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cl3_q <= 1'b0;
      ref_q <= 2'h0;
    end else begin
      if (tk && pin_i.cmd == CMD_MRS)
        cl3_q <= pin_i.addr[4];
      if (tk && pin_i.cmd == CMD_REF && ref_q != 2'h2)
        ref_q <= ref_q + 2'h1;
    end
  end
  a_reset_idle: assert property (disable iff (1'b0) !nrst_i |=> dq_o.oe_n && !ready_o && !suspended_o)
    else $error("outputs busy after reset");
  a_suspend_entry: assert property (!pin_i.cke |=> suspended_o)
    else $error("no suspend after enable low");
  a_suspend_exit: assert property (pin_i.cke |=> !suspended_o)
    else $error("no resume after enable high");
  a_suspend_ready: assert property (suspended_o |-> !ready_o)
    else $error("ready while suspended");
  a_wake_refresh: assert property (ready_o |-> ref_q == 2'h2)
    else $error("ready before two refreshes");
  a_mask_float: assert property (tk && pin_i.cke && pin_i.mask == 2'h3 ##1 pin_i.cke |=> dq_o.oe_n)
    else $error("read mask did not float data");
  a_read_cl2: assert property (rd && !cl3_q ##1 pin_i.cke |=> !dq_o.oe_n)
    else $error("no data two cycles after read");
  a_read_cl3: assert property (rd && cl3_q ##1 pin_i.cke && pin_i.mask == 2'h0 ##1 pin_i.cke |=> !dq_o.oe_n)
    else $error("no data three cycles after read");
  a_pre_float: assert property (tk && cl3_q && pin_i.cke && pin_i.cmd == CMD_PRE ##1 pin_i.cke [*2] |=> dq_o.oe_n)
    else $error("data not floated after precharge");
endmodule : sdt_core_checker

/* File: bench/sdt_ctrl_model.sv */
`timescale 1ns/100ps
// controller stand-in: one command per edge, set at the falling edge
module sdt_ctrl_model
  import sdt_pkg::*;
(
  input  wire logic        clk_i,
  output sdt_pkg::sdt_in_s pin_o
);
  // idle pins at time zero
  initial pin_o = '{cke: 1'b1, cmd: CMD_NOP, default: '0};
  // callers space activates and burst stops
  // command and word held over one edge
  task automatic step(input logic [3:0] c, input logic [12:0] a, input logic [1:0] m, input logic [15:0] d,
                      input logic k);
    @(negedge clk_i);
    pin_o <= '{k, c, 2'h0, a, m, d};
    @(posedge clk_i);
    #1;
  endtask : step
endmodule : sdt_ctrl_model

/* File: bench/sdt_core_bench.sv */
`timescale 1ns/100ps
// runs the core through its controller model, reads checked against a word model
module sdt_core_bench;
  import sdt_pkg::*;
  logic        clk_i;            // system clock
  logic        nrst_i;           // reset, active low
  sdt_in_s     pin;              // controller pins
  sdt_out_s    dq;               // data pins
  logic        ready;            // device usable
  logic        susp;             // clock suspended
  int          n_fail = 0;       // mismatches
  int          checks_done = 0;  // comparisons
  int unsigned st = 72;          // xorshift state
  int          m [2];            // columns 0 and 1
  logic [15:0] w [4];            // write words
  sdt_core dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .pin_i(pin), .dq_o(dq), .ready_o(ready), .suspended_o(susp));
  sdt_ctrl_model ctl_u (.clk_i(clk_i), .pin_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [15:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st[15:0];
  endfunction : xs
  task automatic c(input logic [3:0] cm, input logic [12:0] a);
    ctl_u.step(cm, a, 2'h0, xs(), 1'b1);
  endtask : c
  task automatic n(input int k);
    repeat (k) c(CMD_NOP, 13'h0);
  endtask : n
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // cut a hang short; the sequence needs under 200 cycles
  initial begin
    repeat (2000) @(posedge clk_i);
    n_fail++;
    summarize();
  end
  // main sequence
  initial begin
    nrst_i = 1'b0;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    nrst_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      w[i] = xs();
    end
    chk({dq.oe_n, ready, susp}, 17'h4);
    c(CMD_REF, 13'h0);
    n(2);
    chk(ready, 1'b0);
    c(CMD_REF, 13'h0);
    n(2);
    chk(ready, 1'b1);
    c(CMD_MRS, 13'h001);
    n(2);
    c(CMD_ACT, 13'h0);
    n(1);
    // back to back bursts, second one lane-masked
    ctl_u.step(CMD_WRITE, 13'h0, 2'h0, w[0], 1'b1);
    ctl_u.step(CMD_NOP, 13'h0, 2'h0, w[1], 1'b1);
    ctl_u.step(CMD_WRITE, 13'h0, 2'h2, w[2], 1'b1);
    ctl_u.step(CMD_NOP, 13'h0, 2'h1, w[3], 1'b1);
    m[0] = {w[0][15:8], w[2][7:0]};
    m[1] = {w[3][15:8], w[1][7:0]};
    c(CMD_READ, 13'h0);
    n(1);
    chk({dq.oe_n, dq.data}, {1'b0, 16'(m[0])});
    n(1);
    chk({dq.oe_n, dq.data}, {1'b0, 16'(m[1])});
    c(CMD_READ, 13'h0);
    ctl_u.step(CMD_NOP, 13'h0, 2'h3, xs(), 1'b1);
    chk({dq.oe_n, dq.data}, {1'b0, 16'(m[0])});
    n(1);
    chk(dq.oe_n, 1'b1);
    ctl_u.step(CMD_NOP, 13'h0, 2'h0, xs(), 1'b0);
    chk({susp, ready}, 17'h2);
    ctl_u.step(CMD_READ, 13'h0, 2'h0, xs(), 1'b1);
    chk({susp, ready}, 17'h1);
    n(2);
    chk(dq.oe_n, 1'b1);
    c(CMD_PRE, 13'h0);
    n(2);
    c(CMD_MRS, 13'h013);
    n(2);
    c(CMD_ACT, 13'h0);
    n(1);
    c(CMD_READ, 13'h0);
    n(1);
    c(CMD_PRE, 13'h0);
    chk({dq.oe_n, dq.data}, {1'b0, 16'(m[0])});
    n(1);
    chk({dq.oe_n, dq.data}, {1'b0, 16'(m[1])});
    n(1);
    chk(dq.oe_n, 1'b1);
    @(negedge clk_i);
    nrst_i = 1'b0;
    @(negedge clk_i);
    nrst_i = 1'b1;
    chk(ready, 1'b0);
    summarize();
  end
endmodule : sdt_core_bench
bind sdt_core sdt_core_checker chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .pin_i(pin_i), .dq_o(dq_o),
                                      .ready_o(ready_o), .suspended_o(suspended_o));
